// ### esm_pkg.sv
// constants for the event source select multiplexer
package esm_pkg;
  // register bus
  localparam int          ADDR_W    = 18;
  localparam int          DATA_W    = 32;
  localparam int          REG_W     = 8;
  localparam int          NUM_REGS  = 10;
  // printed register indices; byte address is four times the index
  localparam logic [15:0] IDX_DSP_SEL      = 16'he330;
  localparam logic [15:0] IDX_ADC_GRP_SEL  = 16'he331;
  localparam logic [15:0] IDX_PWM_SEL      = 16'he332;
  localparam logic [15:0] IDX_SERIAL_SEL   = 16'he333;
  localparam logic [15:0] IDX_TIMER_SEL    = 16'he334;
  localparam logic [15:0] IDX_ADC0_LOW     = 16'he335;
  localparam logic [15:0] IDX_ADC0_HIGH    = 16'he336;
  localparam logic [15:0] IDX_ADC1_LOW     = 16'he337;
  localparam logic [15:0] IDX_ADC1_HIGH    = 16'he338;
  localparam logic [15:0] IDX_SAMPLER_SEL  = 16'he339;
  localparam logic [15:0] REG_IDX [NUM_REGS] = '{
    IDX_DSP_SEL, IDX_ADC_GRP_SEL, IDX_PWM_SEL, IDX_SERIAL_SEL, IDX_TIMER_SEL,
    IDX_ADC0_LOW, IDX_ADC0_HIGH, IDX_ADC1_LOW, IDX_ADC1_HIGH, IDX_SAMPLER_SEL};
  // writable bits of each register, others are reserved
  localparam logic [7:0]  REG_MASK [NUM_REGS] = '{
    8'h3f, 8'h3f, 8'h3f, 8'h26, 8'h1e, 8'hff, 8'h0f, 8'hff, 8'h0f, 8'h03};
  localparam logic [7:0]  REG_RESET = 8'h00;
  // register slots
  localparam int          R_DSP     = 0;
  localparam int          R_ADCGRP  = 1;
  localparam int          R_PWM     = 2;
  localparam int          R_SERIAL  = 3;
  localparam int          R_TIMER   = 4;
  localparam int          R_ADC_LOW = 5;
  localparam int          R_SAMPLER = 9;
  // field positions
  localparam int          SERIAL_BIT     = 5;
  localparam int          LUT_BIT0       = 1;
  localparam int          TIMER_BIT0     = 1;
  localparam int          SAMPLER_LO_BIT = 0;
  localparam int          SAMPLER_HI_BIT = 1;
  // structure of the routed signals
  localparam int          THREADS   = 6;
  localparam int          DSP_UNITS = 2;
  localparam int          ADC_GRP_W = 4;
  localparam int          PWM_UNITS = 4;
  localparam int          LUT_THR   = 2;
  localparam int          TIMERS    = 4;
  localparam int          ADCS      = 2;
  localparam int          GROUPS    = 3;
  localparam int          PAIRS     = 4;
  localparam int          PAIR_W    = 2;
  localparam int          EP_EV_W   = PAIRS * PAIR_W;
  localparam int          CMP_GRP   = 3;
endpackage

// ### esm_sel_reg.sv
// one byte-wide select register with reserved bits held at zero
`timescale 1ns/1ps
module esm_sel_reg
  import esm_pkg::*;
#(
  parameter logic [7:0] MASK = 8'hff
)
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // write port
  input  wire logic       wr_en,
  input  wire logic [7:0] wdata,
  // stored value
  output logic      [7:0] value
);
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      value <= REG_RESET;
    else if (wr_en)
      value <= wdata & MASK;
  end
endmodule

// ### esm_sel_mux.sv
// two-way selector of a bundle of event lines
`timescale 1ns/1ps
module esm_sel_mux
#(
  parameter int W = 1
)
(
  // select
  input  wire logic         sel,
  // sources
  input  wire logic [W-1:0] src0,
  input  wire logic [W-1:0] src1,
  // routed result
  output logic      [W-1:0] dst
);
  assign dst = sel ? src1 : src0;
endmodule

// ### esm_event_source_select.sv
// event source select multiplexer with apb register access
`timescale 1ns/1ps
module esm_event_source_select
  import esm_pkg::*;
(
  // clock and reset
  input  wire logic                           clock,
  input  wire logic                           sys_rst,
  // apb slave
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [ADDR_W-1:0]              paddr,
  input  wire logic [DATA_W-1:0]              pwdata,
  input  wire logic [3:0]                     pstrb,
  output logic      [DATA_W-1:0]              prdata,
  output logic                                pready,
  output logic                                pslverr,
  // peripheral event sources
  input  wire logic [DSP_UNITS-1:0]           dsp_event0,
  input  wire logic [DSP_UNITS-1:0]           dsp_event1,
  input  wire logic [ADC_GRP_W-1:0]           adc_group_even,
  input  wire logic [ADC_GRP_W-1:0]           adc_group_odd,
  input  wire logic [PWM_UNITS-1:0]           pwm_event0,
  input  wire logic [PWM_UNITS-1:0]           pwm_event1,
  input  wire logic                           uart_event,
  input  wire logic                           second_serial_unit_event,
  input  wire logic                           lookup_logic_unit_zero_event,
  input  wire logic                           lookup_logic_unit_one_event,
  input  wire logic [TIMERS-1:0]              compare_match_a,
  input  wire logic [TIMERS-1:0]              compare_match_b,
  // event processor thread outputs, events 2 to 9 of each thread
  input  wire logic [THREADS*EP_EV_W-1:0]     event_processor_out,
  input  wire logic [THREADS-1:0]             comparator_event,
  // event processor thread inputs
  output logic      [THREADS*DSP_UNITS-1:0]   thread_dsp_event,
  output logic      [THREADS*ADC_GRP_W-1:0]   thread_adc_event,
  output logic      [THREADS*PWM_UNITS-1:0]   thread_pwm_event,
  output logic                                thread5_serial_event,
  output logic      [LUT_THR-1:0]             thread_lut_event,
  output logic      [TIMERS-1:0]              thread_timer_event,
  // adc triggers, group g pair p at bits [8g+2p +: 2]
  output logic      [GROUPS*EP_EV_W-1:0]      adc0_trigger,
  output logic      [GROUPS*EP_EV_W-1:0]      adc1_trigger,
  // sampling controller channel groups
  output logic      [CMP_GRP-1:0]             sampler_lower_event,
  output logic      [CMP_GRP-1:0]             sampler_upper_event
);
  logic [REG_W-1:0] sel_q   [NUM_REGS];
  logic [NUM_REGS-1:0] hit;
  logic [NUM_REGS-1:0] wr_en;
  logic [REG_W-1:0] rd_val;
  logic             mapped;
  logic             setup_done;
  logic             xfer;
  logic [CMP_GRP-1:0] cmp_even;
  logic [CMP_GRP-1:0] cmp_odd;

  // apb: one wait state, every access completes two cycles after setup
  assign setup_done = psel && penable && !pready;
  assign xfer       = psel && penable && pready;
  assign mapped     = |hit;

  genvar gi;
  genvar gg;
  genvar gp;
  generate
    for (gi = 0; gi < NUM_REGS; gi++)
    begin : g_reg
      assign hit[gi]   = (paddr == {REG_IDX[gi], 2'b00});
      // byte lane 0 holds the whole register
      assign wr_en[gi] = xfer && pwrite && hit[gi] && pstrb[0];
      // reserved bits never store, so they read back zero
      esm_sel_reg #(.MASK(REG_MASK[gi])) u_reg (
        .clock   (clock),
        .sys_rst (sys_rst),
        .wr_en   (wr_en[gi]),
        .wdata   (pwdata[REG_W-1:0]),
        .value   (sel_q[gi])
      );
    end
  endgenerate

  always_comb
  begin
    rd_val = '0;
    for (int i = 0; i < NUM_REGS; i++)
    begin
      if (hit[i])
        rd_val = sel_q[i];
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= setup_done;
      pslverr <= setup_done && !mapped;
      prdata  <= (setup_done && !pwrite) ? {{(DATA_W-REG_W){1'b0}}, rd_val} : '0;
    end
  end

  // thread inputs; routing is purely combinational from the stored bits
  generate
    for (gi = 0; gi < THREADS; gi++)
    begin : g_thr
      esm_sel_mux #(.W(DSP_UNITS)) u_dsp (
        .sel  (sel_q[R_DSP][gi]),
        .src0 (dsp_event0),
        .src1 (dsp_event1),
        .dst  (thread_dsp_event[gi*DSP_UNITS +: DSP_UNITS])
      );
      esm_sel_mux #(.W(ADC_GRP_W)) u_adc (
        .sel  (sel_q[R_ADCGRP][gi]),
        .src0 (adc_group_even),
        .src1 (adc_group_odd),
        .dst  (thread_adc_event[gi*ADC_GRP_W +: ADC_GRP_W])
      );
      esm_sel_mux #(.W(PWM_UNITS)) u_pwm (
        .sel  (sel_q[R_PWM][gi]),
        .src0 (pwm_event0),
        .src1 (pwm_event1),
        .dst  (thread_pwm_event[gi*PWM_UNITS +: PWM_UNITS])
      );
    end
    for (gi = 0; gi < TIMERS; gi++)
    begin : g_tmr
      // timer k feeds thread k+1
      esm_sel_mux #(.W(1)) u_tmr (
        .sel  (sel_q[R_TIMER][TIMER_BIT0 + gi]),
        .src0 (compare_match_a[gi]),
        .src1 (compare_match_b[gi]),
        .dst  (thread_timer_event[gi])
      );
    end
    for (gi = 0; gi < LUT_THR; gi++)
    begin : g_lut
      esm_sel_mux #(.W(1)) u_lut (
        .sel  (sel_q[R_SERIAL][LUT_BIT0 + gi]),
        .src0 (lookup_logic_unit_zero_event),
        .src1 (lookup_logic_unit_one_event),
        .dst  (thread_lut_event[gi])
      );
    end
    // adc a: low register at slot 5+2a, high at 6+2a
    for (gi = 0; gi < ADCS; gi++)
    begin : g_adc
      for (gg = 0; gg < GROUPS; gg++)
      begin : g_grp
        for (gp = 0; gp < PAIRS; gp++)
        begin : g_pair
          localparam int SLOT = R_ADC_LOW + 2 * gi + gg / 2;
          localparam int BIT  = (gg % 2) * PAIRS + gp;
          localparam int T0   = 2 * gg;
          logic [PAIR_W-1:0] pair_out;
          esm_sel_mux #(.W(PAIR_W)) u_pair (
            .sel  (sel_q[SLOT][BIT]),
            .src0 (event_processor_out[T0*EP_EV_W + gp*PAIR_W +: PAIR_W]),
            .src1 (event_processor_out[(T0+1)*EP_EV_W + gp*PAIR_W +: PAIR_W]),
            .dst  (pair_out)
          );
          if (gi == 0)
          begin : g_a0
            assign adc0_trigger[gg*EP_EV_W + gp*PAIR_W +: PAIR_W] = pair_out;
          end
          else
          begin : g_a1
            assign adc1_trigger[gg*EP_EV_W + gp*PAIR_W +: PAIR_W] = pair_out;
          end
        end
      end
    end
    for (gi = 0; gi < CMP_GRP; gi++)
    begin : g_cmp
      assign cmp_even[gi] = comparator_event[2*gi];
      assign cmp_odd[gi]  = comparator_event[2*gi+1];
    end
  endgenerate

  // thread 5 serial choice
  assign thread5_serial_event = sel_q[R_SERIAL][SERIAL_BIT] ? second_serial_unit_event
                                                            : uart_event;

  // comparator groups toward the sampling controller
  esm_sel_mux #(.W(CMP_GRP)) u_cmp_lo (
    .sel  (sel_q[R_SAMPLER][SAMPLER_LO_BIT]),
    .src0 (cmp_even),
    .src1 (cmp_odd),
    .dst  (sampler_lower_event)
  );
  esm_sel_mux #(.W(CMP_GRP)) u_cmp_hi (
    .sel  (sel_q[R_SAMPLER][SAMPLER_HI_BIT]),
    .src0 (cmp_even),
    .src1 (cmp_odd),
    .dst  (sampler_upper_event)
  );

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_wr(logic [15:0] idx);
    psel && penable && pready && pwrite && pstrb[0] && paddr == {idx, 2'b00};
  endsequence

  sequence s_rd_setup;
    psel && !penable && !pwrite;
  endsequence

  property p_dsp_route;
    s_wr(IDX_DSP_SEL) |=>
      thread_dsp_event[1:0] == ($past(pwdata[0]) ? dsp_event1 : dsp_event0);
  endproperty
  a_dsp_route: assert property (p_dsp_route) else $error("dsp routing wrong");

  property p_adc_route;
    s_wr(IDX_ADC_GRP_SEL) |=>
      thread_adc_event[23:20] == ($past(pwdata[5]) ? adc_group_odd : adc_group_even);
  endproperty
  a_adc_route: assert property (p_adc_route) else $error("adc group routing wrong");

  property p_pwm_route;
    s_wr(IDX_PWM_SEL) |=>
      thread_pwm_event[11:8] == ($past(pwdata[2]) ? pwm_event1 : pwm_event0);
  endproperty
  a_pwm_route: assert property (p_pwm_route) else $error("pwm routing wrong");

  property p_serial_route;
    s_wr(IDX_SERIAL_SEL) |=> thread5_serial_event ==
      ($past(pwdata[5]) ? second_serial_unit_event : uart_event);
  endproperty
  a_serial_route: assert property (p_serial_route) else $error("serial routing wrong");

  property p_lut_route;
    s_wr(IDX_SERIAL_SEL) |=> thread_lut_event[1] ==
      ($past(pwdata[2]) ? lookup_logic_unit_one_event : lookup_logic_unit_zero_event);
  endproperty
  a_lut_route: assert property (p_lut_route) else $error("lookup routing wrong");

  property p_timer_route;
    s_wr(IDX_TIMER_SEL) |=> thread_timer_event[3] ==
      ($past(pwdata[4]) ? compare_match_b[3] : compare_match_a[3]);
  endproperty
  a_timer_route: assert property (p_timer_route) else $error("timer routing wrong");

  property p_adc0_low;
    s_wr(IDX_ADC0_LOW) |=> adc0_trigger[15:14] == ($past(pwdata[7]) ?
      event_processor_out[31:30] : event_processor_out[23:22]);
  endproperty
  a_adc0_low: assert property (p_adc0_low) else $error("adc0 low pair wrong");

  property p_adc0_high;
    s_wr(IDX_ADC0_HIGH) |=> adc0_trigger[17:16] == ($past(pwdata[0]) ?
      event_processor_out[41:40] : event_processor_out[33:32]);
  endproperty
  a_adc0_high: assert property (p_adc0_high) else $error("adc0 high pair wrong");

  property p_adc1_low;
    s_wr(IDX_ADC1_LOW) |=> adc1_trigger[3:2] == ($past(pwdata[1]) ?
      event_processor_out[11:10] : event_processor_out[3:2]);
  endproperty
  a_adc1_low: assert property (p_adc1_low) else $error("adc1 low pair wrong");

  property p_adc1_high;
    s_wr(IDX_ADC1_HIGH) |=> adc1_trigger[23:22] == ($past(pwdata[3]) ?
      event_processor_out[47:46] : event_processor_out[39:38]);
  endproperty
  a_adc1_high: assert property (p_adc1_high) else $error("adc1 high pair wrong");

  property p_sampler;
    s_wr(IDX_SAMPLER_SEL) |=>
      sampler_upper_event == ($past(pwdata[1]) ? cmp_odd : cmp_even) &&
      sampler_lower_event == ($past(pwdata[0]) ? cmp_odd : cmp_even);
  endproperty
  a_sampler: assert property (p_sampler) else $error("sampler routing wrong");

  property p_reserved_zero;
    s_rd_setup ##1 (psel && penable && paddr == {IDX_SERIAL_SEL, 2'b00}) ##1 pready |->
      prdata[7:6] == 2'b00 && prdata[4:3] == 2'b00 && prdata[0] == 1'b0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit read one");

  property p_reset_clear;
    @(posedge clock) disable iff (1'b0)
    sys_rst |=> sel_q[R_DSP] == REG_RESET && sel_q[R_SAMPLER] == REG_RESET && !pready;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("select not cleared");
endmodule

// ### esm_event_partner.sv
// peripheral event sources and event processor outputs for the select bench
`timescale 1ns/1ps
module esm_event_partner
  import esm_pkg::*;
(
  // pattern chosen by the bench
  input  wire logic [31:0]                pat,
  // first-listed and second-listed sources
  output logic      [DSP_UNITS-1:0]       dsp_event0,
  output logic      [DSP_UNITS-1:0]       dsp_event1,
  output logic      [ADC_GRP_W-1:0]       adc_group_even,
  output logic      [ADC_GRP_W-1:0]       adc_group_odd,
  output logic      [PWM_UNITS-1:0]       pwm_event0,
  output logic      [PWM_UNITS-1:0]       pwm_event1,
  output logic                            uart_event,
  output logic                            second_serial_unit_event,
  output logic                            lookup_logic_unit_zero_event,
  output logic                            lookup_logic_unit_one_event,
  output logic      [TIMERS-1:0]          compare_match_a,
  output logic      [TIMERS-1:0]          compare_match_b,
  // thread outputs and comparator events
  output logic      [THREADS*EP_EV_W-1:0] event_processor_out,
  output logic      [THREADS-1:0]         comparator_event
);
  // second source is the complement of the first, so a wrong select flips every bit
  assign {dsp_event0, adc_group_even, pwm_event0, uart_event, lookup_logic_unit_zero_event,
          compare_match_a} = pat[15:0];
  assign {dsp_event1, adc_group_odd, pwm_event1, second_serial_unit_event,
          lookup_logic_unit_one_event, compare_match_b} = ~pat[15:0];
  // neighbouring threads carry opposite bytes, so a wrong thread choice shows
  assign event_processor_out = {3{~pat[23:16], pat[23:16]}};
  assign comparator_event    = {3{~pat[24], pat[24]}};
endmodule

// ### esm_event_source_select_tb_top.sv
// self-checking bench for the event source select multiplexer
`timescale 1ns/1ps
module esm_event_source_select_tb_top
  import esm_pkg::*;
;
  typedef struct packed {logic [3:0] slot; logic [7:0] wd; logic [7:0] rd;} esm_row_s;
  localparam logic [31:0] PAT = 32'h005a_9a5c;
  logic                         clock, sys_rst, psel, penable, pwrite, pready, pslverr, erv;
  logic [ADDR_W-1:0]            paddr;
  logic [31:0]                  pwdata, prdata, rdv, pat;
  logic [3:0]                   pstrb;
  logic [DSP_UNITS-1:0]         dsp_event0, dsp_event1;
  logic [ADC_GRP_W-1:0]         adc_group_even, adc_group_odd;
  logic [PWM_UNITS-1:0]         pwm_event0, pwm_event1;
  logic                         uart_event, second_serial_unit_event, thread5_serial_event;
  logic                         lookup_logic_unit_zero_event, lookup_logic_unit_one_event;
  logic [TIMERS-1:0]            compare_match_a, compare_match_b, thread_timer_event;
  logic [THREADS*EP_EV_W-1:0]   event_processor_out;
  logic [THREADS-1:0]           comparator_event;
  logic [THREADS*DSP_UNITS-1:0] thread_dsp_event;
  logic [23:0]                  thread_adc_event, thread_pwm_event, adc0_trigger, adc1_trigger;
  logic [LUT_THR-1:0]           thread_lut_event;
  logic [CMP_GRP-1:0]           sampler_lower_event, sampler_upper_event;
  logic [7:0]                   r [10];
  int                           errors, checked, cycles;
  // writes of all ones also set reserved bits on purpose
  esm_row_s rows [30] = '{
    '{4'd0,8'hff,8'h3f}, '{4'd1,8'hff,8'h3f}, '{4'd2,8'hff,8'h3f}, '{4'd3,8'hff,8'h26},
    '{4'd4,8'hff,8'h1e}, '{4'd5,8'hff,8'hff}, '{4'd6,8'hff,8'h0f}, '{4'd7,8'hff,8'hff},
    '{4'd8,8'hff,8'h0f}, '{4'd9,8'hff,8'h03}, '{4'd0,8'h5a,8'h1a}, '{4'd1,8'h5a,8'h1a},
    '{4'd2,8'h5a,8'h1a}, '{4'd3,8'h5a,8'h02}, '{4'd4,8'h5a,8'h1a}, '{4'd5,8'h5a,8'h5a},
    '{4'd6,8'h5a,8'h0a}, '{4'd7,8'h5a,8'h5a}, '{4'd8,8'h5a,8'h0a}, '{4'd9,8'h5a,8'h02},
    '{4'd0,8'ha5,8'h25}, '{4'd1,8'ha5,8'h25}, '{4'd2,8'ha5,8'h25}, '{4'd3,8'ha5,8'h24},
    '{4'd4,8'ha5,8'h04}, '{4'd5,8'ha5,8'ha5}, '{4'd6,8'ha5,8'h05}, '{4'd7,8'ha5,8'ha5},
    '{4'd8,8'ha5,8'h05}, '{4'd9,8'ha5,8'h01}};

  esm_event_partner i_esm_event_partner (.pat(pat), .dsp_event0(dsp_event0),
    .dsp_event1(dsp_event1), .adc_group_even(adc_group_even), .adc_group_odd(adc_group_odd),
    .pwm_event0(pwm_event0), .pwm_event1(pwm_event1), .uart_event(uart_event),
    .second_serial_unit_event(second_serial_unit_event),
    .lookup_logic_unit_zero_event(lookup_logic_unit_zero_event),
    .lookup_logic_unit_one_event(lookup_logic_unit_one_event),
    .compare_match_a(compare_match_a), .compare_match_b(compare_match_b),
    .event_processor_out(event_processor_out), .comparator_event(comparator_event));

  esm_event_source_select i_esm_event_source_select (.clock(clock), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dsp_event0(dsp_event0), .dsp_event1(dsp_event1), .adc_group_even(adc_group_even),
    .adc_group_odd(adc_group_odd), .pwm_event0(pwm_event0), .pwm_event1(pwm_event1),
    .uart_event(uart_event), .second_serial_unit_event(second_serial_unit_event),
    .lookup_logic_unit_zero_event(lookup_logic_unit_zero_event),
    .lookup_logic_unit_one_event(lookup_logic_unit_one_event),
    .compare_match_a(compare_match_a), .compare_match_b(compare_match_b),
    .event_processor_out(event_processor_out), .comparator_event(comparator_event),
    .thread_dsp_event(thread_dsp_event), .thread_adc_event(thread_adc_event),
    .thread_pwm_event(thread_pwm_event), .thread5_serial_event(thread5_serial_event),
    .thread_lut_event(thread_lut_event), .thread_timer_event(thread_timer_event),
    .adc0_trigger(adc0_trigger), .adc1_trigger(adc1_trigger),
    .sampler_lower_event(sampler_lower_event), .sampler_upper_event(sampler_upper_event));

  always #2 clock = ~clock;

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(string nm, logic [127:0] seen, logic [127:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      check("timeout", 1'b0, 1'b1);
      wrap_up();
    end
  end

  function automatic logic [ADDR_W-1:0] addr(int i);
    return {REG_IDX[i], 2'b00};
  endfunction

  // leaves the request up, so a second call may follow at once
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                     input logic [3:0] s, output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    pstrb   <= s;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1);
    // the slave answers after exactly one wait state
    check("wait states", n, 2);
    rd = prdata;
    er = pslverr;
  endtask

  task automatic idle();
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr_reg(int slot, logic [7:0] d);
    apb(1'b1, addr(slot), d, 4'hf, rdv, erv);
    check("write error", erv, 1'b0);
  endtask

  task automatic rd_chk(int slot, logic [7:0] exp);
    apb(1'b0, addr(slot), 8'h00, 4'h0, rdv, erv);
    check($sformatf("reg %0d", slot), {erv, rdv}, {1'b0, 24'h0, exp});
  endtask

  function automatic logic [1:0] ep_pair(int i, logic s);
    return event_processor_out[8*(2*(i/4) + s) + 2*(i%4) +: 2];
  endfunction

  // routing against the shadow copy r, with both source patterns
  task automatic check_routes();
    logic [11:0] e_dsp;
    logic [23:0] e_adc, e_pwm, e_a0, e_a1;
    logic [3:0]  e_tim;
    logic [1:0]  e_lut;
    logic [2:0]  e_lo, e_hi;
    logic        e_ser;
    for (int k = 0; k < 2; k++)
    begin
      pat <= k[0] ? ~PAT : PAT;
      @(negedge clock);
      for (int n = 0; n < THREADS; n++)
      begin
        e_dsp[2*n +: 2] = r[0][n] ? dsp_event1 : dsp_event0;
        e_adc[4*n +: 4] = r[1][n] ? adc_group_odd : adc_group_even;
        e_pwm[4*n +: 4] = r[2][n] ? pwm_event1 : pwm_event0;
      end
      for (int i = 0; i < 4; i++)
        e_tim[i] = r[4][i+1] ? compare_match_b[i] : compare_match_a[i];
      for (int i = 0; i < 2; i++)
        e_lut[i] = r[3][i+1] ? lookup_logic_unit_one_event : lookup_logic_unit_zero_event;
      for (int i = 0; i < 12; i++)
      begin
        e_a0[2*i +: 2] = ep_pair(i, i < 8 ? r[5][i] : r[6][i-8]);
        e_a1[2*i +: 2] = ep_pair(i, i < 8 ? r[7][i] : r[8][i-8]);
      end
      for (int i = 0; i < 3; i++)
      begin
        e_lo[i] = comparator_event[2*i + r[9][0]];
        e_hi[i] = comparator_event[2*i + r[9][1]];
      end
      e_ser = r[3][5] ? second_serial_unit_event : uart_event;
      check("dsp", thread_dsp_event, e_dsp);
      check("adc group", thread_adc_event, e_adc);
      check("pwm", thread_pwm_event, e_pwm);
      check("serial", thread5_serial_event, e_ser);
      check("lookup", thread_lut_event, e_lut);
      check("timer", thread_timer_event, e_tim);
      check("adc0", adc0_trigger, e_a0);
      check("adc1", adc1_trigger, e_a1);
      check("sampler low", sampler_lower_event, e_lo);
      check("sampler high", sampler_upper_event, e_hi);
      @(posedge clock);
    end
  endtask

  initial
  begin
    {clock, psel, penable, pwrite, paddr, pwdata, pstrb, pat} = '0;
    sys_rst = 1'b1;
    errors  = 0;
    checked = 0;
    cycles  = 0;
    foreach (r[i]) r[i] = 8'h00;
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    check_routes();
    foreach (rows[i])
    begin
      wr_reg(rows[i].slot, rows[i].wd);
      idle();
      rd_chk(rows[i].slot, rows[i].rd);
      idle();
      r[rows[i].slot] = rows[i].rd;
      check_routes();
    end
    $display("test table done");
    apb(1'b1, 18'h38ce8, 8'hff, 4'hf, rdv, erv);
    idle();
    check("unmapped write", erv, 1'b1);
    apb(1'b0, 18'h38ce8, 8'h00, 4'h0, rdv, erv);
    idle();
    check("unmapped read", {erv, rdv}, {1'b1, 32'h0});
    rd_chk(0, r[0]);
    idle();
    $display("test unmapped done");
    // low byte strobe off: the write must not land
    apb(1'b1, addr(5), 8'h00, 4'he, rdv, erv);
    idle();
    rd_chk(5, r[5]);
    idle();
    $display("test strobe done");
    wr_reg(5, 8'h3c);
    rd_chk(5, 8'h3c);
    wr_reg(9, 8'h03);
    rd_chk(9, 8'h03);
    idle();
    r[5] = 8'h3c;
    r[9] = 8'h03;
    check_routes();
    $display("test back to back done");
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    foreach (r[i])
    begin
      rd_chk(i, 8'h00);
      idle();
      r[i] = 8'h00;
    end
    check_routes();
    $display("test reset done");
    wrap_up();
  end
endmodule
